/* hdl/mask_if.sv */
// Carrier of one set's rise and fall masks between storage and filter
`timescale 1ns/1ps
interface mask_if;
	logic [15:0] rise_mask;
	logic [15:0] fall_mask;
	modport owner (output rise_mask, output fall_mask);
	modport user  (input rise_mask, input fall_mask);
endinterface : mask_if

/* hdl/mask_pair.sv */
// Rise and fall mask storage for one register set
`timescale 1ns/1ps
module mask_pair
	import status_filter_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        preset,
	input  wire logic        wr_rise,
	input  wire logic        wr_fall,
	input  wire logic [15:0] wdata,
	mask_if.owner            m
);
	logic [15:0] rise_r;
	logic [15:0] rise_nxt;
	logic [15:0] fall_r;
	logic [15:0] fall_nxt;

	// Preset beats a write in the same cycle
	always_comb begin
		rise_nxt = rise_r;
		fall_nxt = fall_r;
		if (preset) begin
			rise_nxt = RISE_MASK_RST;
			fall_nxt = FALL_MASK_RST;
		end else begin
			if (wr_rise)
				rise_nxt = wdata;
			if (wr_fall)
				fall_nxt = wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rise_r <= RISE_MASK_RST;
			fall_r <= FALL_MASK_RST;
		end else begin
			rise_r <= rise_nxt;
			fall_r <= fall_nxt;
		end
	end

	assign m.rise_mask = rise_r;
	assign m.fall_mask = fall_r;
endmodule : mask_pair

/* hdl/status_filter_pkg.sv */
// Constants for the status transition filter bank
package status_filter_pkg;

	localparam int unsigned   SET_COUNT = 6;
	localparam int unsigned   BIT_COUNT = 16;

	// Register set indices
	localparam logic [2:0]    SET_MEAS = 3'h0;
	localparam logic [2:0]    SET_QUES = 3'h1;
	localparam logic [2:0]    SET_OPER = 3'h2;
	localparam logic [2:0]    SET_TRIG = 3'h3;
	localparam logic [2:0]    SET_ARM  = 3'h4;
	localparam logic [2:0]    SET_SEQ  = 3'h5;

	// Register selected by a command
	typedef enum logic [1:0] {
		REG_RISE,
		REG_FALL,
		REG_EVENT,
		REG_COND
	} reg_sel_t;

	// Reset and preset values
	localparam logic [15:0]   RISE_MASK_RST = 16'hffff;
	localparam logic [15:0]   FALL_MASK_RST = 16'h0000;

	// Measurement bit positions
	localparam int unsigned   reading_over_range      = 0;
	localparam int unsigned   below_first_low_limit   = 1;
	localparam int unsigned   above_first_high_limit  = 2;
	localparam int unsigned   below_second_low_limit  = 3;
	localparam int unsigned   above_second_high_limit = 4;
	localparam int unsigned   reading_ready           = 5;
	localparam int unsigned   buffer_has_readings     = 7;
	localparam int unsigned   buffer_half             = 8;
	localparam int unsigned   buffer_full_flag        = 9;
	localparam int unsigned   buffer_pretrigger_done  = 11;

	// Questionable bit positions
	localparam int unsigned   QUES_TEMP = 4;
	localparam int unsigned   QUES_CAL  = 8;
	localparam int unsigned   QUES_WARN = 14;

	// Operation bit positions
	localparam int unsigned   OPER_CAL    = 0;
	localparam int unsigned   OPER_SETTLE = 1;
	localparam int unsigned   OPER_TRIG   = 5;
	localparam int unsigned   OPER_ARM    = 6;
	localparam int unsigned   OPER_CALC   = 9;
	localparam int unsigned   OPER_IDLE   = 10;

	// Bits that carry an event; all others never latch
	localparam logic [15:0]   MEAS_VALID = 16'h0bbf;
	localparam logic [15:0]   QUES_VALID = 16'h4110;
	localparam logic [15:0]   OPER_VALID = 16'h0663;
	localparam logic [15:0]   TRIG_VALID = 16'h0002;
	localparam logic [15:0]   ARM_VALID  = 16'h0002;
	localparam logic [15:0]   SEQ_VALID  = 16'h0006;

endpackage : status_filter_pkg

/* hdl/status_transition_bank.sv */
// Six-set positive and negative transition filter bank with command port
// Behaviour
// - Six sets, each with own rise mask
// - Power-up sets all rise mask bits
// - Preset sets rise masks; clear-status keeps them
// - Enabled rising condition sets event bit
// - Mask one enables, zero disables detection
// - Mask query returns current bits exactly
// - Measurement bit 0 is reading overflow
// - Bits 1,2 are first low/high limits
// - Bits 3,4 are second low/high limits
// - Measurement bit 5 is reading ready
// - Bit 7 means buffer holds two readings
// - Bits 8,9 are buffer half and full
// - Bit 11 pretrigger; others have no event
// - Questionable bit 4 is temperature summary
// - Questionable bit 8 is calibration summary
// - Bit 14 command warning; bit 15 zero
// - Operation bits 0,1 calibrating and settling
// - Operation bits 5,6 trigger and arm wait
// - Operation bits 9,10 calculating and idle
// - Each set has matching fall mask
// - Enabled falling condition sets event bit
// - Power-up and preset clear fall masks
`timescale 1ns/1ps
module status_transition_bank
	import status_filter_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        cmd_valid,
	input  wire logic        cmd_write,
	input  wire logic [2:0]  cmd_set,
	input  wire reg_sel_t    cmd_reg,
	input  wire logic [15:0] cmd_wdata,
	input  wire logic        preset,
	input  wire logic        clear_status,
	input  wire logic [15:0] cond_meas,
	input  wire logic [15:0] cond_ques,
	input  wire logic [15:0] cond_oper,
	input  wire logic [15:0] cond_trig,
	input  wire logic [15:0] cond_arm,
	input  wire logic [15:0] cond_seq,
	output logic             rsp_valid,
	output logic      [15:0] rsp_data,
	output logic      [15:0] event_meas,
	output logic      [15:0] event_ques,
	output logic      [15:0] event_oper,
	output logic      [15:0] event_trig,
	output logic      [15:0] event_arm,
	output logic      [15:0] event_seq
);
	logic [15:0] cond_a  [SET_COUNT];
	logic [15:0] ev_a    [SET_COUNT];
	logic [15:0] rise_a  [SET_COUNT];
	logic [15:0] fall_a  [SET_COUNT];
	logic [15:0] valid_a [SET_COUNT];
	logic        wr_rise [SET_COUNT];
	logic        wr_fall [SET_COUNT];

	logic        rsp_valid_r;
	logic        rsp_valid_nxt;
	logic [15:0] rsp_data_r;
	logic [15:0] rsp_data_nxt;

	always_comb begin
		cond_a[0]  = cond_meas;
		cond_a[1]  = cond_ques;
		cond_a[2]  = cond_oper;
		cond_a[3]  = cond_trig;
		cond_a[4]  = cond_arm;
		cond_a[5]  = cond_seq;
		valid_a[0] = MEAS_VALID;
		valid_a[1] = QUES_VALID;
		valid_a[2] = OPER_VALID;
		valid_a[3] = TRIG_VALID;
		valid_a[4] = ARM_VALID;
		valid_a[5] = SEQ_VALID;
	end

	// One mask pair and one filter per set
	for (genvar i = 0; i < SET_COUNT; i++) begin : g_set
		mask_if mi ();

		assign wr_rise[i] = cmd_valid && cmd_write && cmd_set == 3'(i)
		                    && cmd_reg == REG_RISE;
		assign wr_fall[i] = cmd_valid && cmd_write && cmd_set == 3'(i)
		                    && cmd_reg == REG_FALL;
		assign rise_a[i]  = mi.rise_mask;
		assign fall_a[i]  = mi.fall_mask;

		mask_pair u_masks (
			.clk_sys (clk_sys),
			.rst_n   (rst_n),
			.preset  (preset),
			.wr_rise (wr_rise[i]),
			.wr_fall (wr_fall[i]),
			.wdata   (cmd_wdata),
			.m       (mi)
		);

		// Filter needs an elaboration-time constant, not the query copy
		localparam logic [15:0] SET_VALID = (i == 0) ? MEAS_VALID
		                                  : (i == 1) ? QUES_VALID
		                                  : (i == 2) ? OPER_VALID
		                                  : (i == 3) ? TRIG_VALID
		                                  : (i == 4) ? ARM_VALID
		                                  : SEQ_VALID;

		transition_filter #(
			.VALID (SET_VALID)
		) u_filter (
			.clk_sys      (clk_sys),
			.rst_n        (rst_n),
			.clear_events (clear_status),
			.cond         (cond_a[i]),
			.m            (mi),
			.events       (ev_a[i])
		);
	end

	// Query path; an unknown set answers zero, a write answers nothing
	always_comb begin
		rsp_valid_nxt = cmd_valid && !cmd_write;
		rsp_data_nxt  = rsp_data_r;
		if (cmd_valid && !cmd_write) begin
			rsp_data_nxt = 16'h0000;
			if (cmd_set < 3'(SET_COUNT)) begin
				case (cmd_reg)
					REG_RISE:  rsp_data_nxt = rise_a[cmd_set];
					REG_FALL:  rsp_data_nxt = fall_a[cmd_set];
					REG_EVENT: rsp_data_nxt = ev_a[cmd_set];
					default:   rsp_data_nxt = cond_a[cmd_set] & valid_a[cmd_set];
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rsp_valid_r <= 1'b0;
			rsp_data_r  <= 16'h0000;
		end else begin
			rsp_valid_r <= rsp_valid_nxt;
			rsp_data_r  <= rsp_data_nxt;
		end
	end

	assign rsp_valid  = rsp_valid_r;
	assign rsp_data   = rsp_data_r;
	assign event_meas = ev_a[0];
	assign event_ques = ev_a[1];
	assign event_oper = ev_a[2];
	assign event_trig = ev_a[3];
	assign event_arm  = ev_a[4];
	assign event_seq  = ev_a[5];

	property p_reset_masks;
		@(posedge clk_sys) !rst_n |=> (rise_a[0] == 16'hffff && fall_a[5] == 16'h0000);
	endproperty
	a_reset_masks: assert property (p_reset_masks) else $error("masks wrong after reset");

	property p_preset_rise;
		@(posedge clk_sys) disable iff (!rst_n)
		preset |=> (rise_a[2] == 16'hffff && rise_a[5] == 16'hffff);
	endproperty
	a_preset_rise: assert property (p_preset_rise) else $error("preset left rise mask");

	property p_preset_fall;
		@(posedge clk_sys) disable iff (!rst_n)
		preset |=> (fall_a[0] == 16'h0000 && fall_a[1] == 16'h0000);
	endproperty
	a_preset_fall: assert property (p_preset_fall) else $error("preset left fall mask");

	property p_cls_keeps;
		@(posedge clk_sys) disable iff (!rst_n)
		(clear_status && !preset && !cmd_valid) |=> (rise_a[1] == $past(rise_a[1])
		                                            && fall_a[1] == $past(fall_a[1]));
	endproperty
	a_cls_keeps: assert property (p_cls_keeps) else $error("clear changed a mask");

	property p_rise_sets;
		@(posedge clk_sys) disable iff (!rst_n)
		($rose(cond_meas[reading_over_range]) && rise_a[0][reading_over_range])
		|=> event_meas[reading_over_range] ##1 (event_meas[reading_over_range] || $past(clear_status));
	endproperty
	a_rise_sets: assert property (p_rise_sets) else $error("rising edge lost");

	property p_masked;
		@(posedge clk_sys) disable iff (!rst_n)
		($rose(cond_meas[below_first_low_limit]) && !rise_a[0][below_first_low_limit]
		 && !event_meas[below_first_low_limit]) |=> !event_meas[below_first_low_limit];
	endproperty
	a_masked: assert property (p_masked) else $error("masked edge latched");

	property p_fall_sets;
		@(posedge clk_sys) disable iff (!rst_n)
		($fell(cond_ques[QUES_TEMP]) && fall_a[1][QUES_TEMP]) |=> event_ques[QUES_TEMP];
	endproperty
	a_fall_sets: assert property (p_fall_sets) else $error("falling edge lost");

	property p_query;
		@(posedge clk_sys) disable iff (!rst_n)
		(cmd_valid && !cmd_write && cmd_set == SET_OPER && cmd_reg == REG_RISE)
		|=> (rsp_valid && rsp_data == $past(rise_a[2]));
	endproperty
	a_query: assert property (p_query) else $error("query answer wrong");

	property p_ques15;
		@(posedge clk_sys) disable iff (!rst_n) !event_ques[15] && !event_meas[6];
	endproperty
	a_ques15: assert property (p_ques15) else $error("unassigned bit latched");

	property p_sticky;
		@(posedge clk_sys) disable iff (!rst_n)
		(event_oper[OPER_CAL] && !clear_status) |=> event_oper[OPER_CAL];
	endproperty
	a_sticky: assert property (p_sticky) else $error("event dropped");

	property p_write_fall;
		@(posedge clk_sys) disable iff (!rst_n)
		(cmd_valid && cmd_write && cmd_set == SET_SEQ && cmd_reg == REG_FALL && !preset)
		|=> fall_a[5] == $past(cmd_wdata);
	endproperty
	a_write_fall: assert property (p_write_fall) else $error("fall mask write lost");

	// Shared write data must only land in the addressed set
	property p_sets_apart;
		@(posedge clk_sys) disable iff (!rst_n)
		(cmd_valid && cmd_write && cmd_set == SET_MEAS && !preset)
		|=> (rise_a[1] == $past(rise_a[1]) && fall_a[1] == $past(fall_a[1]));
	endproperty
	a_sets_apart: assert property (p_sets_apart) else $error("write reached another set");

	property p_unmapped;
		@(posedge clk_sys) disable iff (!rst_n)
		(cmd_valid && !cmd_write && cmd_set > SET_SEQ) |=> (rsp_valid && rsp_data == 16'h0000);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped set gave data");

	property p_no_answer;
		@(posedge clk_sys) disable iff (!rst_n)
		!(cmd_valid && !cmd_write) |=> !rsp_valid;
	endproperty
	a_no_answer: assert property (p_no_answer) else $error("answer without query");

	property p_high_one;
		@(posedge clk_sys) disable iff (!rst_n)
		($rose(cond_meas[above_first_high_limit]) && rise_a[0][above_first_high_limit])
		|=> event_meas[above_first_high_limit];
	endproperty
	a_high_one: assert property (p_high_one) else $error("first high limit lost");

	property p_high_two;
		@(posedge clk_sys) disable iff (!rst_n)
		($rose(cond_meas[above_second_high_limit]) && rise_a[0][above_second_high_limit])
		|=> event_meas[above_second_high_limit];
	endproperty
	a_high_two: assert property (p_high_two) else $error("second high limit lost");

	property p_ready;
		@(posedge clk_sys) disable iff (!rst_n)
		($rose(cond_meas[reading_ready]) && rise_a[0][reading_ready]) |=> event_meas[reading_ready];
	endproperty
	a_ready: assert property (p_ready) else $error("reading ready lost");

	property p_avail;
		@(posedge clk_sys) disable iff (!rst_n)
		($rose(cond_meas[buffer_has_readings]) && rise_a[0][buffer_has_readings])
		|=> event_meas[buffer_has_readings];
	endproperty
	a_avail: assert property (p_avail) else $error("buffer readings lost");

	property p_half;
		@(posedge clk_sys) disable iff (!rst_n)
		($rose(cond_meas[buffer_half]) && rise_a[0][buffer_half]) |=> event_meas[buffer_half];
	endproperty
	a_half: assert property (p_half) else $error("buffer half lost");

	property p_pretrig;
		@(posedge clk_sys) disable iff (!rst_n)
		($rose(cond_meas[buffer_pretrigger_done]) && rise_a[0][buffer_pretrigger_done])
		|=> event_meas[buffer_pretrigger_done];
	endproperty
	a_pretrig: assert property (p_pretrig) else $error("pretrigger lost");

	property p_ques_cal;
		@(posedge clk_sys) disable iff (!rst_n)
		($rose(cond_ques[QUES_CAL]) && rise_a[1][QUES_CAL]) |=> event_ques[QUES_CAL];
	endproperty
	a_ques_cal: assert property (p_ques_cal) else $error("calibration summary lost");

	property p_settle;
		@(posedge clk_sys) disable iff (!rst_n)
		($rose(cond_oper[OPER_SETTLE]) && rise_a[2][OPER_SETTLE]) |=> event_oper[OPER_SETTLE];
	endproperty
	a_settle: assert property (p_settle) else $error("settling lost");

	property p_arm_wait;
		@(posedge clk_sys) disable iff (!rst_n)
		($fell(cond_oper[OPER_ARM]) && fall_a[2][OPER_ARM]) |=> event_oper[OPER_ARM];
	endproperty
	a_arm_wait: assert property (p_arm_wait) else $error("arm wait lost");

	property p_idle;
		@(posedge clk_sys) disable iff (!rst_n)
		($rose(cond_oper[OPER_IDLE]) && rise_a[2][OPER_IDLE]) |=> event_oper[OPER_IDLE];
	endproperty
	a_idle: assert property (p_idle) else $error("idle entry lost");

	property p_both_edges;
		@(posedge clk_sys) disable iff (!rst_n)
		($changed(cond_meas[reading_over_range]) && rise_a[0][reading_over_range]
		 && fall_a[0][reading_over_range]) |=> event_meas[reading_over_range];
	endproperty
	a_both_edges: assert property (p_both_edges) else $error("two-way edge lost");

	c_rise: cover property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(event_meas[buffer_full_flag]));
	c_fall: cover property (@(posedge clk_sys) disable iff (!rst_n)
		$fell(cond_ques[QUES_WARN]) ##1 $rose(event_ques[QUES_WARN]));
	c_write_query: cover property (@(posedge clk_sys) disable iff (!rst_n)
		(cmd_valid && cmd_write && cmd_reg == REG_RISE) ##1 (cmd_valid && !cmd_write));
	c_preset: cover property (@(posedge clk_sys) disable iff (!rst_n) preset);
endmodule : status_transition_bank

/* hdl/transition_filter.sv */
// Edge detection and sticky event latch for one register set
`timescale 1ns/1ps
module transition_filter
	import status_filter_pkg::*;
#(
	parameter logic [15:0] VALID = 16'hffff
)(
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        clear_events,
	input  wire logic [15:0] cond,
	mask_if.user             m,
	output logic      [15:0] events
);
	logic [15:0] prev_r;
	logic [15:0] prev_nxt;
	logic [15:0] ev_r;
	logic [15:0] ev_nxt;
	logic [15:0] hit;
	logic [15:0] cond_v;

	always_comb begin
		cond_v   = cond & VALID;
		prev_nxt = cond_v;
		hit      = (cond_v & ~prev_r & m.rise_mask)
		         | (~cond_v & prev_r & m.fall_mask);
		// Set wins over clear so no edge is lost
		ev_nxt = (clear_events ? 16'h0000 : ev_r) | hit;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			prev_r <= 16'h0000;
			ev_r   <= 16'h0000;
		end else begin
			prev_r <= prev_nxt;
			ev_r   <= ev_nxt;
		end
	end

	assign events = ev_r;
endmodule : transition_filter

/* verification/host_model.sv */
// Host side model that issues status commands on the command port
`timescale 1ns/1ps
module host_model
	import status_filter_pkg::*;
(
	input  wire logic   clk_sys,
	output logic        cmd_valid,
	output logic        cmd_write,
	output logic [2:0]  cmd_set,
	output reg_sel_t    cmd_reg,
	output logic [15:0] cmd_wdata
);
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_set   = 3'h0;
		cmd_reg   = REG_RISE;
		cmd_wdata = 16'h0000;
	end

	// Mask goes over as its weight sum, one binary word
	task automatic send(input logic wr, input logic [2:0] s, input reg_sel_t r,
		input logic [15:0] d);
		@(posedge clk_sys);
		#1;
		cmd_valid = 1'b1;
		cmd_write = wr;
		cmd_set   = s;
		cmd_reg   = r;
		cmd_wdata = d;
		@(posedge clk_sys);
		#1;
		cmd_valid = 1'b0;
		// Released data is scrambled so stale values cannot pass
		cmd_wdata = ~d;
	endtask : send
endmodule : host_model

/* verification/tb.sv */
// Self-checking bench for the status transition filter bank
`timescale 1ns/1ps
module tb
	import status_filter_pkg::*;
;
	typedef struct packed {
		logic [2:0]  s;
		logic [15:0] rise;
		logic [15:0] fall;
		logic [15:0] c0;
		logic [15:0] c1;
		logic [15:0] exp;
	} row_t;

	localparam row_t ROWS [9] = '{
		'{3'h0, 16'hffff, 16'h0000, 16'h0000, 16'hffff, 16'h0bbf},
		'{3'h0, 16'h0220, 16'h0000, 16'h0000, 16'hffff, 16'h0220},
		'{3'h1, 16'hffff, 16'h0000, 16'h0000, 16'hffff, 16'h4110},
		'{3'h1, 16'h0000, 16'h4010, 16'hffff, 16'h0000, 16'h4010},
		'{3'h2, 16'h0402, 16'h0000, 16'h0000, 16'hffff, 16'h0402},
		'{3'h2, 16'h0000, 16'hffff, 16'hffff, 16'h0000, 16'h0663},
		'{3'h3, 16'hffff, 16'h0000, 16'h0000, 16'hffff, 16'h0002},
		'{3'h4, 16'h0000, 16'h0000, 16'h0000, 16'hffff, 16'h0000},
		'{3'h5, 16'h0004, 16'h0002, 16'h0002, 16'h0004, 16'h0006}
	};

	logic        clk_sys      = 1'b0;
	logic        rst_n        = 1'b0;
	logic        preset       = 1'b0;
	logic        clear_status = 1'b0;
	logic [15:0] cond_a [6]   = '{default: 16'h0000};
	logic [15:0] ev [6];
	logic        cmd_valid;
	logic        cmd_write;
	logic        rsp_valid;
	logic [2:0]  cmd_set;
	reg_sel_t    cmd_reg;
	logic [15:0] cmd_wdata;
	logic [15:0] rsp_data;
	int          n_mismatch   = 0;
	int          n_compared   = 0;

	always #5 clk_sys = ~clk_sys;

	host_model host (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_set(cmd_set), .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata));

	status_transition_bank dut (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid),
		.cmd_write(cmd_write), .cmd_set(cmd_set), .cmd_reg(cmd_reg),
		.cmd_wdata(cmd_wdata), .preset(preset), .clear_status(clear_status),
		.cond_meas(cond_a[0]), .cond_ques(cond_a[1]), .cond_oper(cond_a[2]),
		.cond_trig(cond_a[3]), .cond_arm(cond_a[4]), .cond_seq(cond_a[5]),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .event_meas(ev[0]),
		.event_ques(ev[1]), .event_oper(ev[2]), .event_trig(ev[3]),
		.event_arm(ev[4]), .event_seq(ev[5]));

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : check

	task automatic query(input logic [2:0] s, input reg_sel_t r, input logic [15:0] exp);
		host.send(1'b0, s, r, 16'h0000);
		check({15'h0000, rsp_valid}, 16'h0001);
		check(rsp_data, exp);
	endtask : query

	task automatic clr;
		clear_status = 1'b1;
		@(posedge clk_sys);
		#1;
		clear_status = 1'b0;
	endtask : clr

	task automatic do_reset;
		rst_n = 1'b0;
		repeat (20) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
	endtask : do_reset

	task automatic results;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : results

	initial begin
		#100000;
		n_mismatch++;
		results();
	end

	initial begin
		do_reset();
		for (int i = 0; i < 6; i++) begin
			query(i[2:0], REG_RISE, RISE_MASK_RST);
			query(i[2:0], REG_FALL, FALL_MASK_RST);
			check(ev[i], 16'h0000);
		end
		query(3'h6, REG_RISE, 16'h0000);
		foreach (ROWS[k]) begin
			host.send(1'b1, ROWS[k].s, REG_RISE, ROWS[k].rise);
			host.send(1'b1, ROWS[k].s, REG_FALL, ROWS[k].fall);
			query(ROWS[k].s, REG_RISE, ROWS[k].rise);
			cond_a[ROWS[k].s] = ROWS[k].c0;
			repeat (2) @(posedge clk_sys);
			#1;
			clr();
			cond_a[ROWS[k].s] = ROWS[k].c1;
			repeat (3) @(posedge clk_sys);
			#1;
			check(ev[ROWS[k].s], ROWS[k].exp);
			query(ROWS[k].s, REG_EVENT, ROWS[k].exp);
		end
		query(3'h0, REG_COND, MEAS_VALID);
		clr();
		check(ev[5], 16'h0000);
		// Same position armed both ways: each edge latches after one cycle
		host.send(1'b1, 3'h0, REG_RISE, 16'h0001);
		host.send(1'b1, 3'h0, REG_FALL, 16'h0001);
		cond_a[0] = 16'h0000;
		repeat (2) @(posedge clk_sys);
		#1;
		clr();
		cond_a[0] = 16'h0001;
		@(posedge clk_sys);
		#1;
		check(ev[0], 16'h0001);
		clr();
		cond_a[0] = 16'h0000;
		@(posedge clk_sys);
		#1;
		check(ev[0], 16'h0001);
		host.send(1'b1, 3'h2, REG_RISE, 16'h0000);
		host.send(1'b1, 3'h2, REG_FALL, 16'hffff);
		clr();
		query(3'h2, REG_RISE, 16'h0000);
		query(3'h2, REG_FALL, 16'hffff);
		preset = 1'b1;
		@(posedge clk_sys);
		#1;
		preset = 1'b0;
		query(3'h2, REG_RISE, 16'hffff);
		query(3'h2, REG_FALL, 16'h0000);
		cond_a[2] = 16'h0001;
		host.send(1'b1, 3'h3, REG_RISE, 16'h0000);
		check(ev[2], 16'h0001);
		do_reset();
		check(ev[2], 16'h0000);
		query(3'h3, REG_RISE, RISE_MASK_RST);
		// Condition still high at release counts as a rising edge
		check(ev[3], TRIG_VALID);
		results();
	end
endmodule : tb
